// file: common/psw_pkg.sv
// Notes on behaviour
// - Add or add-with-carry sets carry when a carry leaves the top bit.
// - Subtract, subtract-with-borrow and compare set carry on borrow.
// - Rotate, shift, bit, move, multiply and decimal adjust may load carry.
// - Half-carry changes only on byte ops: carry or borrow at bit 3.
// - Bits 5 and 1 are user flags that hardware never touches.
// - Bank field 4:3 picks R0-R7 at 00H, 08H, 10H or 18H.
// - Overflow is set when a signed add or subtract leaves the range.
// - Overflow is also set on a multiply past one byte or divide by zero.
// - Parity is set when the accumulator holds an odd count of ones.
// - Parity is recomputed only when the accumulator is written.
package status_pkg;

  // Register offset and reset value.
  localparam logic [7:0] STATUS_OFFSET = 8'hD0;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Field positions.
  localparam int CARRY_POS = 7;
  localparam int HALF_POS = 6;
  localparam int USER_A_POS = 5;
  localparam int BANK_HI_POS = 4;
  localparam int BANK_LO_POS = 3;
  localparam int RANGE_POS = 2;
  localparam int USER_B_POS = 1;
  localparam int PARITY_POS = 0;

  // Bank base addresses are spaced by this many bytes.
  localparam int BANK_SIZE = 8;

  // Kinds of flag-producing operation.
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD,
    OP_SUB,
    OP_MUL,
    OP_DIV,
    OP_CARRY_LOAD
  } alu_op_e;

  // One operation result from the execution datapath.
  typedef struct packed {
    logic valid;
    alu_op_e op;
    logic byte_op;
    logic [7:0] a;
    logic [7:0] b;
    logic carry_in;
    logic mul_hi_nz;
    logic carry_value;
  } alu_req_s;

  // Accumulator write report.
  typedef struct packed {
    logic write;
    logic [7:0] value;
  } acc_upd_s;

  // Register bus request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

// file: rtl/flag_calc.sv
`timescale 1ns/1ps
// Combinational flag arithmetic for one operation.
module flag_calc (
  // Operation.
  input wire status_pkg::alu_req_s req_in,
  // Flag results.
  output logic carry_out,
  output logic half_out,
  output logic range_out,
  output logic carry_upd_out,
  output logic half_upd_out,
  output logic range_upd_out
);

  // Sum and difference with their nibble and sign behaviour.
  always_comb begin
    logic [8:0] sum;
    logic [8:0] dif;
    logic [4:0] nsum;
    logic [4:0] ndif;
    sum = {1'b0, req_in.a} + {1'b0, req_in.b} + {8'h00, req_in.carry_in};
    dif = {1'b0, req_in.a} - {1'b0, req_in.b} - {8'h00, req_in.carry_in};
    nsum = {1'b0, req_in.a[3:0]} + {1'b0, req_in.b[3:0]}
      + {4'h0, req_in.carry_in};
    ndif = {1'b0, req_in.a[3:0]} - {1'b0, req_in.b[3:0]}
      - {4'h0, req_in.carry_in};
    carry_out = 1'b0;
    half_out = 1'b0;
    range_out = 1'b0;
    carry_upd_out = 1'b0;
    half_upd_out = 1'b0;
    range_upd_out = 1'b0;
    if (req_in.valid) begin
      unique case (req_in.op)
        status_pkg::OP_ADD: begin
          carry_out = sum[8];
          carry_upd_out = 1'b1;
          half_out = nsum[4];
          half_upd_out = req_in.byte_op;
          range_out = (req_in.a[7] == req_in.b[7])
            && (sum[7] != req_in.a[7]);
          range_upd_out = 1'b1;
        end
        status_pkg::OP_SUB: begin
          carry_out = dif[8];
          carry_upd_out = 1'b1;
          half_out = ndif[4];
          half_upd_out = req_in.byte_op;
          range_out = (req_in.a[7] != req_in.b[7])
            && (dif[7] != req_in.a[7]);
          range_upd_out = 1'b1;
        end
        status_pkg::OP_MUL: begin
          range_out = req_in.mul_hi_nz;
          range_upd_out = 1'b1;
          carry_out = 1'b0;
          carry_upd_out = 1'b1;
        end
        status_pkg::OP_DIV: begin
          range_out = (req_in.b == 8'h00);
          range_upd_out = 1'b1;
          carry_out = 1'b0;
          carry_upd_out = 1'b1;
        end
        status_pkg::OP_CARRY_LOAD: begin
          carry_out = req_in.carry_value;
          carry_upd_out = 1'b1;
        end
        status_pkg::OP_NONE: begin
        end
        default: begin
        end
      endcase
    end
  end

endmodule

// file: rtl/program_status_flags.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
// Program status word with hardware flag updates and software access.
module program_status_flags (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Execution datapath.
  input wire status_pkg::alu_req_s alu_in,
  input wire status_pkg::acc_upd_s acc_in,
  // Register bus.
  input wire status_pkg::reg_req_s bus_in,
  output logic [7:0] rdata_out,
  // Status view.
  output logic [7:0] program_status_word_out,
  output logic [7:0] bank_base_out
);

  // All state of the block: the status word, the read-back register
  // and the bank base that follows the select bits.
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] rdata;
    logic [7:0] base;
  } state_s;

  // Registered state and its next value.
  state_s state_ff;
  state_s nxt_state;

  // Flag values from the arithmetic helper.
  logic c_val;
  logic h_val;
  logic v_val;

  // Per-flag update enables from the arithmetic helper.
  logic c_upd;
  logic h_upd;
  logic v_upd;

  // Bus strobes that hit the status word.
  logic sel_wr;
  logic sel_rd;

  // True when a bus address selects the status word.
  function automatic logic hits_status(input logic [7:0] addr);
    hits_status = (addr == status_pkg::STATUS_OFFSET);
  endfunction

  // Bank base address for a bank select value.
  function automatic logic [7:0] bank_base(input logic [1:0] sel);
    bank_base = 8'(int'(sel) * status_pkg::BANK_SIZE);
  endfunction

  // Signed overflow of an 8-bit addition with carry in.
  function automatic logic add_ovf(input logic [7:0] a,
      input logic [7:0] b, input logic c);
    logic [7:0] r;
    r = a + b + {7'h00, c};
    add_ovf = (a[7] == b[7]) && (r[7] != a[7]);
  endfunction

  // Signed overflow of an 8-bit subtraction with borrow in.
  function automatic logic sub_ovf(input logic [7:0] a,
      input logic [7:0] b, input logic c);
    logic [7:0] r;
    r = a - b - {7'h00, c};
    sub_ovf = (a[7] != b[7]) && (r[7] != a[7]);
  endfunction

  flag_calc u_calc (
    .req_in(alu_in),
    .carry_out(c_val),
    .half_out(h_val),
    .range_out(v_val),
    .carry_upd_out(c_upd),
    .half_upd_out(h_upd),
    .range_upd_out(v_upd)
  );

  // Strobes shared by the update logic and the hold and idle checks; the read and write sequences decode the address again.
  assign sel_wr = bus_in.wr && hits_status(bus_in.addr);
  assign sel_rd = bus_in.rd && hits_status(bus_in.addr);

  // Software write first, then instruction flags so they win.
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rdata = 8'h00;
    // A read returns the word as it stood before this edge.
    if (sel_rd) begin
      nxt_state.rdata = state_ff.status;
    end
    // Unmapped writes fall through and change nothing.
    if (sel_wr) begin
      nxt_state.status = bus_in.wdata;
    end
    if (c_upd) begin
      nxt_state.status[status_pkg::CARRY_POS] = c_val;
    end
    if (h_upd) begin
      nxt_state.status[status_pkg::HALF_POS] = h_val;
    end
    if (v_upd) begin
      nxt_state.status[status_pkg::RANGE_POS] = v_val;
    end
    // Parity follows every accumulator write, alias writes included.
    if (acc_in.write) begin
      nxt_state.status[status_pkg::PARITY_POS] = ^acc_in.value;
    end
    // The base follows the bank bits of the next word, so both move
    // on the same edge.
    nxt_state.base = bank_base(
      nxt_state.status[status_pkg::BANK_HI_POS:status_pkg::BANK_LO_POS]);
  end

  // State register with synchronous reset.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      state_ff <= '{status: status_pkg::STATUS_RESET, rdata: 8'h00,
        base: 8'h00};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs come straight from the state register.
  assign rdata_out = state_ff.rdata;
  assign program_status_word_out = state_ff.status;
  assign bank_base_out = state_ff.base;

  // An add operation offered at this edge.
  sequence add_op_s;
    alu_in.valid && alu_in.op == status_pkg::OP_ADD;
  endsequence

  // A subtract or compare operation offered at this edge.
  sequence sub_op_s;
    alu_in.valid && alu_in.op == status_pkg::OP_SUB;
  endsequence

  // A multiply operation offered at this edge.
  sequence mul_op_s;
    alu_in.valid && alu_in.op == status_pkg::OP_MUL;
  endsequence

  // A divide operation offered at this edge.
  sequence div_op_s;
    alu_in.valid && alu_in.op == status_pkg::OP_DIV;
  endsequence

  // A software read of the status word taken at this edge.
  sequence status_read_s;
    bus_in.rd && hits_status(bus_in.addr);
  endsequence

  // A software write of the status word taken at this edge.
  sequence status_write_s;
    bus_in.wr && hits_status(bus_in.addr);
  endsequence

  // Carry after an add follows the 9-bit sum.
  chk_add_carry: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    add_op_s |=>
    program_status_word_out[7] == $past(({1'b0, alu_in.a}
      + {1'b0, alu_in.b} + {8'h00, alu_in.carry_in}) >> 8))
    else $error("carry wrong after add");

  // Carry after a subtract is the borrow out of the top bit.
  chk_sub_borrow: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    sub_op_s |=>
    program_status_word_out[7] == $past(alu_in.a < (9'(alu_in.b)
      + 9'(alu_in.carry_in))))
    else $error("borrow wrong after subtract");

  // Carry loads from the datapath for the other carry instructions.
  chk_carry_load: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    alu_in.valid && alu_in.op == status_pkg::OP_CARRY_LOAD |=>
    program_status_word_out[7] == $past(alu_in.carry_value))
    else $error("carry load lost");

  // Multiply leaves carry clear.
  chk_mul_carry: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    mul_op_s |=> !program_status_word_out[7])
    else $error("carry set after multiply");

  // Divide leaves carry clear.
  chk_div_carry: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    div_op_s |=> !program_status_word_out[7])
    else $error("carry set after divide");

  // Carry holds when neither an operation nor software touches it.
  chk_carry_hold: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    !alu_in.valid && !sel_wr |=> $stable(program_status_word_out[7]))
    else $error("carry moved while idle");

  // Half-carry after a byte add is the carry out of bit 3.
  chk_add_half: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    add_op_s ##0 alu_in.byte_op |=>
    program_status_word_out[6] == $past(({1'b0, alu_in.a[3:0]}
      + {1'b0, alu_in.b[3:0]} + {4'h0, alu_in.carry_in}) >> 4))
    else $error("half-carry wrong after add");

  // Half-carry after a byte subtract is the borrow into bit 3.
  chk_sub_half: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    sub_op_s ##0 alu_in.byte_op |=>
    program_status_word_out[6] == $past({1'b0, alu_in.a[3:0]}
      < ({1'b0, alu_in.b[3:0]} + {4'h0, alu_in.carry_in})))
    else $error("half-carry wrong after subtract");

  // Half-carry holds across wide operations.
  chk_half_hold: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    !alu_in.byte_op && !sel_wr |=>
    $stable(program_status_word_out[6]))
    else $error("half-carry moved on wide op");

  // User flags change only by software.
  chk_user_flags: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    !sel_wr |=>
    $stable(program_status_word_out[5]) && $stable(program_status_word_out[1]))
    else $error("user flag changed by hardware");

  // A software write lands in the user flags even beside an operation.
  chk_user_write: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    status_write_s |=>
    program_status_word_out[5] == $past(bus_in.wdata[5])
    && program_status_word_out[1] == $past(bus_in.wdata[1]))
    else $error("user flag write lost");

  // A read returns the word that stood when it was taken.
  chk_read_data: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    status_read_s |=> rdata_out == $past(program_status_word_out))
    else $error("read data wrong");

  // Read data stand one cycle only and are zero otherwise.
  chk_read_idle: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    !sel_rd |=> rdata_out == 8'h00)
    else $error("read data without a read");

  // Bank base always matches the select bits.
  chk_bank_base: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    bank_base_out == {3'b000, program_status_word_out[4:3], 3'b000})
    else $error("bank base mismatch");

  // Bank select bits are loaded by software only.
  chk_bank_write: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    status_write_s |=>
    program_status_word_out[4:3] == $past(bus_in.wdata[4:3]))
    else $error("bank select write lost");

  // Bank select bits hold without a software write.
  chk_bank_hold: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    !sel_wr |=> $stable(program_status_word_out[4:3]))
    else $error("bank select moved by hardware");

  // Overflow after an add follows the signed range.
  chk_add_range: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    add_op_s |=> program_status_word_out[2]
      == $past(add_ovf(alu_in.a, alu_in.b, alu_in.carry_in)))
    else $error("overflow wrong after add");

  // Overflow after a subtract follows the signed range.
  chk_sub_range: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    sub_op_s |=> program_status_word_out[2]
      == $past(sub_ovf(alu_in.a, alu_in.b, alu_in.carry_in)))
    else $error("overflow wrong after subtract");

  // Overflow holds when neither an operation nor software touches it.
  chk_range_hold: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    !alu_in.valid && !sel_wr |=> $stable(program_status_word_out[2]))
    else $error("overflow moved while idle");

  // Divide by zero raises overflow.
  chk_div_zero: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    div_op_s ##0 alu_in.b == 8'h00 |=>
    program_status_word_out[2])
    else $error("divide by zero not flagged");

  // Divide by a nonzero value clears overflow.
  chk_div_ok: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    div_op_s ##0 alu_in.b != 8'h00 |=>
    !program_status_word_out[2])
    else $error("overflow set on a good divide");

  // Multiply overflow follows the high byte of the product.
  chk_mul_range: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    mul_op_s |=> program_status_word_out[2] == $past(alu_in.mul_hi_nz))
    else $error("multiply overflow wrong");

  // Parity follows the accumulator on every write.
  chk_parity_set: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    acc_in.write |=> program_status_word_out[0] == $past(^acc_in.value))
    else $error("parity wrong");

  // Parity holds without an accumulator or software write.
  chk_parity_hold: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    !acc_in.write && !sel_wr |=>
    $stable(program_status_word_out[0]))
    else $error("parity changed without acc write");

  // An operation's carry beats a software write in the same cycle.
  chk_hw_wins: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    status_write_s ##0 alu_in.valid
    && alu_in.op == status_pkg::OP_CARRY_LOAD |=>
    program_status_word_out[7] == $past(alu_in.carry_value))
    else $error("software write beat flag update");

  // The largest positive byte plus one overflows.
  chk_signed_add: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    add_op_s ##0 alu_in.a == 8'h7F && alu_in.b == 8'h01
    && !alu_in.carry_in |=>
    program_status_word_out[2])
    else $error("signed overflow missed");

endmodule

// file: sim/datapath_model.sv
`timescale 1ns/1ps
// Stand-in for the execution datapath: it issues one operation per
// cycle and reports the accumulator write that arithmetic makes.
module datapath_model (
  // Clock.
  input wire logic clk_in,
  // Command from the bench.
  input wire status_pkg::alu_req_s cmd_in,
  // Results toward the status word.
  output status_pkg::alu_req_s alu_out,
  output status_pkg::acc_upd_s acc_out
);
  logic [8:0] res;
  logic wr;

  // The accumulator takes the arithmetic result.
  always_comb begin
    wr = cmd_in.valid
      && cmd_in.op inside {status_pkg::OP_ADD, status_pkg::OP_SUB};
    if (cmd_in.op == status_pkg::OP_SUB) begin
      res = {1'b0, cmd_in.a} - cmd_in.b - cmd_in.carry_in;
    end else begin
      res = {1'b0, cmd_in.a} + cmd_in.b + cmd_in.carry_in;
    end
  end

  // Outputs start idle so nothing is unknown at time zero.
  initial begin
    alu_out = '0;
    acc_out = '0;
  end

  // An unused value field flips so stale data never looks valid.
  always @(posedge clk_in) begin
    alu_out <= cmd_in;
    acc_out.write <= wr;
    acc_out.value <= wr ? res[7:0] : ~acc_out.value;
  end
endmodule

// file: sim/testbench.sv
`timescale 1ns/1ps
// Random operations mixed with software writes and read-back.
module testbench;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  status_pkg::alu_req_s cmd = '0;
  status_pkg::alu_req_s alu;
  status_pkg::acc_upd_s acc;
  status_pkg::reg_req_s bus = '0;
  status_pkg::alu_req_s c;
  logic [7:0] rdata, status_word, base, ex, wd, ad;
  logic sw;
  int error_cnt = 0;
  int num_checks = 0;

  // Clock of 10 ns period.
  always #5 sys_clk = ~sys_clk;

  datapath_model partner (.clk_in(sys_clk), .cmd_in(cmd),
    .alu_out(alu), .acc_out(acc));
  program_status_flags uut (.sys_clk_in(sys_clk), .reset_n_in(reset_n),
    .alu_in(alu), .acc_in(acc), .bus_in(bus), .rdata_out(rdata),
    .program_status_word_out(status_word), .bank_base_out(base));

  // Counts one comparison and reports a difference.
  task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
    num_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Status word after an optional software write and one operation;
  // the operation's flags are applied last.
  function automatic logic [7:0] next_status(logic [7:0] p,
      status_pkg::alu_req_s q, logic w, logic [7:0] d);
    logic [8:0] s;
    logic [4:0] h;
    logic add;
    add = q.op == status_pkg::OP_ADD;
    s = add ? {1'b0, q.a} + q.b + q.carry_in : {1'b0, q.a} - q.b - q.carry_in;
    h = add ? {1'b0, q.a[3:0]} + q.b[3:0] + q.carry_in :
      {1'b0, q.a[3:0]} - q.b[3:0] - q.carry_in;
    if (w) p = d;
    case (q.op)
      status_pkg::OP_ADD, status_pkg::OP_SUB: begin
        p[7] = s[8];
        if (q.byte_op) p[6] = h[4];
        p[2] = (add == (q.a[7] == q.b[7])) && s[7] != q.a[7];
        p[0] = ^s[7:0];
      end
      status_pkg::OP_MUL: begin
        p[7] = 1'b0;
        p[2] = q.mul_hi_nz;
      end
      status_pkg::OP_DIV: begin
        p[7] = 1'b0;
        p[2] = q.b == 8'h00;
      end
      status_pkg::OP_CARRY_LOAD: p[7] = q.carry_value;
      default: p = p;
    endcase
    return p;
  endfunction

  // Cuts a hang short.
  initial begin
    repeat (3000) @(posedge sys_clk);
    error_cnt++;
    complete_run();
  end

  // Main sequence; the first two steps are fixed corner cases.
  initial begin
    void'($urandom(35714));
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    cmp8(status_word, status_pkg::STATUS_RESET);
    cmp8(base, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 300; i++) begin
      c = 24'($urandom);
      c.valid = 1'b1;
      c.op = status_pkg::alu_op_e'(3'($urandom_range(5)));
      if (i < 2) begin
        c.op = i ? status_pkg::OP_DIV : status_pkg::OP_ADD;
        c.a = 8'h7F;
        c.b = i ? 8'h00 : 8'h01;
        c.carry_in = 1'b0;
      end
      sw = 1'($urandom);
      wd = 8'($urandom);
      ad = ($urandom_range(3) == 0) ? 8'hD1 : status_pkg::STATUS_OFFSET;
      ex = next_status(status_word, c, sw && ad == 8'hD0, wd);
      // Requests change only by non-blocking assignment at an edge.
      @(posedge sys_clk);
      cmd <= c;
      @(posedge sys_clk);
      cmd.valid <= 1'b0;
      bus.addr <= ad;
      bus.wdata <= wd;
      bus.wr <= sw;
      @(posedge sys_clk);
      bus.wr <= 1'b0;
      bus.rd <= 1'b1;
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1;
      cmp8(status_word, ex);
      cmp8({7'h00, status_word[0]}, {7'h00, ex[0]});
      cmp8(base, {3'h0, ex[4:3], 3'h0});
      cmp8(rdata, (ad == 8'hD0) ? ex : 8'h00);
    end
    $display("random operation test done");
    complete_run();
  end
endmodule
